// file: hw/boot_mode_selector.sv
`timescale 1ns/100ps
`include "boot_mode_map.svh"
// Function
// RULE_01: Capture select bits on reset input rise
// RULE_02: Code 11 selects user mode, user flash
// RULE_03: Code 10 selects standard download, fetch remapped
// RULE_04: Code 01 activates selective boot path
// RULE_05: Selective boot also remaps fetches, own sequence
// RULE_06: Signature of two words checked against reference
// RULE_07: Signature match gives software reset, user code
// RULE_08: Mismatch reads user key for channel
// RULE_09: Key picks standard, UART, CAN or loop
// RULE_10: Standard loader watches UART and CAN lines
// RULE_11: UART start condition runs UART loader
// RULE_12: Valid CAN dominant bit runs CAN loader
// RULE_13: Code 00 reserved, no boot path taken
// RULE_14: First detected channel locks out the other
module boot_mode_selector
  import boot_mode_pkg::*;
#(
  parameter logic [15:0] REF_SIG = `BM_REF_SIG,
  parameter logic [7:0] SWRST_CYC = `BM_SWRST_CYC,
  parameter logic [7:0] DOM_CYC = `BM_DOM_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Configuration pins
  input wire logic external_reset_input_in,
  input wire logic boot_select_high_bit_in,
  input wire logic boot_select_low_bit_in,
  // Flash contents read by the selective path
  input wire user_sig_t user_sig_in,
  input wire logic [15:0] user_key_in,
  // Download channels
  input wire logic uart_receive_line_in,
  input wire logic first_can_receive_line_in,
  // Boot status
  output boot_status_t status_out
);

  ////////////////////////////////////////////////////////////////////
  // State
  boot_state_t state, next_state;
  boot_sel_t sel, next_sel;
  logic rst_prev, next_rst_prev;
  logic uart_prev, next_uart_prev;
  logic en_uart, next_en_uart;
  logic en_can, next_en_can;
  logic [7:0] dom_cnt, next_dom_cnt;
  logic [7:0] swrst_cnt, next_swrst_cnt;
  boot_status_t next_status;
  logic rst_rise;
  logic uart_start;
  logic can_valid;
  logic sig_ok;

  // Event detectors
  assign rst_rise = external_reset_input_in & ~rst_prev; // RULE_01
  assign uart_start = uart_prev & ~uart_receive_line_in; // RULE_11
  assign can_valid = (dom_cnt >= DOM_CYC); // RULE_12
  assign sig_ok = (16'(user_sig_in.word0 + user_sig_in.word1) == REF_SIG); // RULE_06

  ////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_state = state;
    next_sel = sel;
    next_rst_prev = external_reset_input_in;
    next_uart_prev = uart_receive_line_in;
    next_en_uart = en_uart;
    next_en_can = en_can;
    next_swrst_cnt = swrst_cnt;
    next_dom_cnt = 8'h00;
    case (state)
      ST_WAIT: begin
        if (rst_rise) begin
          next_sel = '{high: boot_select_high_bit_in, low: boot_select_low_bit_in}; // RULE_01
          next_state = ST_DECODE;
        end
      end
      ST_DECODE: begin
        case (sel)
          `BM_SEL_USER: next_state = ST_USER; // RULE_02
          `BM_SEL_STD: begin
            next_en_uart = 1'b1; // RULE_03
            next_en_can = 1'b1;
            next_state = ST_SCAN;
          end
          `BM_SEL_ALT: next_state = ST_SIG; // RULE_04
          default: next_state = ST_RSVD; // RULE_13
        endcase
      end
      ST_SIG: begin
        if (sig_ok) begin
          next_swrst_cnt = SWRST_CYC; // RULE_07
          next_state = ST_SWRST;
        end else begin
          next_state = ST_KEY; // RULE_08
        end
      end
      ST_KEY: begin
        // Key read once here to choose the channel
        case (user_key_in) // RULE_09
          `BM_KEY_STD: begin
            next_en_uart = 1'b1;
            next_en_can = 1'b1;
            next_state = ST_SCAN;
          end
          `BM_KEY_UART: begin
            next_en_uart = 1'b1;
            next_state = ST_SCAN;
          end
          `BM_KEY_CAN: begin
            next_en_can = 1'b1;
            next_state = ST_SCAN;
          end
          default: next_state = ST_LOOP;
        endcase
      end
      ST_SWRST: begin
        next_swrst_cnt = swrst_cnt - 8'h01; // RULE_07
        if (swrst_cnt == 8'h01) begin
          next_state = ST_USER;
        end
      end
      ST_SCAN: begin
        // Count a low CAN level, saturating at the filter length
        if (en_can && !first_can_receive_line_in) begin
          next_dom_cnt = can_valid ? dom_cnt : dom_cnt + 8'h01; // RULE_10
        end
        // UART wins a tie; the other channel is disabled for good
        if (en_uart && uart_start) begin
          next_en_can = 1'b0; // RULE_14
          next_state = ST_UART; // RULE_11
        end else if (en_can && can_valid) begin
          next_en_uart = 1'b0; // RULE_14
          next_state = ST_CAN; // RULE_12
        end
      end
      ST_USER, ST_UART, ST_CAN, ST_LOOP, ST_RSVD: begin
        next_state = state;
      end
      default: next_state = ST_WAIT;
    endcase
    // Reset input held low puts the sequencer back to waiting
    if (!external_reset_input_in) begin
      next_state = ST_WAIT;
      next_en_uart = 1'b0;
      next_en_can = 1'b0;
      next_dom_cnt = 8'h00;
      next_swrst_cnt = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Output decode from the next state
  always_comb begin
    next_status = '0;
    next_status.path = next_sel;
    next_status.user_code = (next_state == ST_USER); // RULE_02
    next_status.sw_reset = (next_state == ST_SWRST); // RULE_07
    next_status.uart_boot = (next_state == ST_UART); // RULE_11
    next_status.can_boot = (next_state == ST_CAN); // RULE_12
    next_status.endless_loop = (next_state == ST_LOOP); // RULE_09
    next_status.reserved = (next_state == ST_RSVD); // RULE_13
    // Fetches at the bottom address go to the boot flash
    next_status.fetch_boot_flash = (next_state == ST_SIG) || (next_state == ST_KEY) ||
      (next_state == ST_SWRST) || (next_state == ST_SCAN) ||
      (next_state == ST_UART) || (next_state == ST_CAN) ||
      (next_state == ST_LOOP); // RULE_03 RULE_05
  end

  ////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state <= ST_WAIT;
      sel <= '0;
      rst_prev <= 1'b1;
      uart_prev <= 1'b1;
      en_uart <= 1'b0;
      en_can <= 1'b0;
      dom_cnt <= 8'h00;
      swrst_cnt <= 8'h00;
      status_out <= '0;
    end else begin
      state <= next_state;
      sel <= next_sel;
      rst_prev <= next_rst_prev;
      uart_prev <= next_uart_prev;
      en_uart <= next_en_uart;
      en_can <= next_en_can;
      dom_cnt <= next_dom_cnt;
      swrst_cnt <= next_swrst_cnt;
      status_out <= next_status;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  property p_capture;
    (state == ST_WAIT) && rst_rise |=>
      sel == {$past(boot_select_high_bit_in), $past(boot_select_low_bit_in)};
  endproperty
  a_capture: assert property (p_capture) else $error("select not captured"); // RULE_01

  property p_user;
    (state == ST_DECODE) && (sel == `BM_SEL_USER) && external_reset_input_in |=>
      status_out.user_code && !status_out.fetch_boot_flash;
  endproperty
  a_user: assert property (p_user) else $error("user mode wrong"); // RULE_02

  property p_std;
    (state == ST_DECODE) && (sel == `BM_SEL_STD) && external_reset_input_in |=>
      status_out.fetch_boot_flash && en_uart && en_can;
  endproperty
  a_std: assert property (p_std) else $error("standard path wrong"); // RULE_03

  property p_alt;
    (state == ST_DECODE) && (sel == `BM_SEL_ALT) && external_reset_input_in |=>
      (state == ST_SIG) && status_out.fetch_boot_flash;
  endproperty
  a_alt: assert property (p_alt) else $error("selective path not taken"); // RULE_04

  property p_sig;
    (state == ST_SIG) && external_reset_input_in |=>
      (state == ($past(sig_ok) ? ST_SWRST : ST_KEY));
  endproperty
  a_sig: assert property (p_sig) else $error("signature branch wrong"); // RULE_06

  property p_swrst;
    (state == ST_SIG) && sig_ok && external_reset_input_in ##1
      external_reset_input_in [*8] |=> status_out.user_code;
  endproperty
  a_swrst: assert property (p_swrst) else $error("no user code after reset"); // RULE_07

  property p_key_loop;
    (state == ST_KEY) && external_reset_input_in && (user_key_in != `BM_KEY_STD) &&
      (user_key_in != `BM_KEY_UART) && (user_key_in != `BM_KEY_CAN) |=>
      status_out.endless_loop;
  endproperty
  a_key_loop: assert property (p_key_loop) else $error("loop not entered"); // RULE_09

  property p_uart;
    (state == ST_SCAN) && en_uart && uart_start && external_reset_input_in |=>
      status_out.uart_boot && !en_can;
  endproperty
  a_uart: assert property (p_uart) else $error("uart loader missed"); // RULE_11

  property p_can;
    (state == ST_SCAN) && en_can && can_valid && !(en_uart && uart_start) &&
      external_reset_input_in |=> status_out.can_boot;
  endproperty
  a_can: assert property (p_can) else $error("can loader missed"); // RULE_12

  property p_rsvd;
    status_out.reserved |-> (status_out.path == `BM_SEL_RSVD) &&
      !status_out.uart_boot && !status_out.can_boot &&
      !status_out.user_code && !status_out.fetch_boot_flash;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved code booted"); // RULE_13

  property p_lock;
    (state == ST_UART) && external_reset_input_in |=> (state == ST_UART);
  endproperty
  a_lock: assert property (p_lock) else $error("channel lock lost"); // RULE_14

  // Selective path keeps code fetches on the boot flash while it checks
  property p_alt_fetch;
    (state == ST_SIG) || (state == ST_KEY) |->
      status_out.fetch_boot_flash && (status_out.path == `BM_SEL_ALT);
  endproperty
  a_alt_fetch: assert property (p_alt_fetch) else $error("fetch not remapped"); // RULE_05

  // A signature miss reads the key, which picks the enabled channel
  property p_key_read;
    (state == ST_KEY) && external_reset_input_in && (user_key_in == `BM_KEY_UART) |=>
      (state == ST_SCAN) && en_uart && !en_can;
  endproperty
  a_key_read: assert property (p_key_read) else $error("key channel wrong"); // RULE_08

  // A low CAN level in the scan state advances the dominant filter
  property p_dom_count;
    (state == ST_SCAN) && en_can && !first_can_receive_line_in && !can_valid &&
      external_reset_input_in |=> (dom_cnt == $past(dom_cnt) + 8'h01);
  endproperty
  a_dom_count: assert property (p_dom_count) else $error("dominant filter stalled"); // RULE_10

  // Once CAN has won, the UART side stays disabled
  property p_lock_can;
    (state == ST_CAN) |-> !en_uart;
  endproperty
  a_lock_can: assert property (p_lock_can) else $error("uart still enabled"); // RULE_14

  // Main scenarios
  cover property ((state == ST_SCAN) ##1 (state == ST_UART));
  cover property ((state == ST_SCAN) ##1 (state == ST_CAN));
  cover property ((state == ST_SWRST) ##1 (state == ST_USER));
  cover property ((state == ST_KEY) ##1 (state == ST_LOOP));
  cover property ((state == ST_DECODE) ##1 (state == ST_RSVD));

endmodule : boot_mode_selector

// file: hw/boot_mode_map.svh
`ifndef BOOT_MODE_MAP_SVH
`define BOOT_MODE_MAP_SVH

// Boot select codes, high bit then low bit
`define BM_SEL_USER 2'h3
`define BM_SEL_STD 2'h2
`define BM_SEL_ALT 2'h1
`define BM_SEL_RSVD 2'h0

// Code fetch address that is redirected to the boot flash
`define BM_FETCH_ADDR 24'h00_0000

// User key codes; any other key value means endless loop
`define BM_KEY_STD 16'h0001
`define BM_KEY_UART 16'h0002
`define BM_KEY_CAN 16'h0003

// Arbitrary default of the reference signature
`define BM_REF_SIG 16'h5A3C

// Software reset pulse length in cycles
`define BM_SWRST_CYC 8'h08

// Cycles a CAN low level must last to count as a valid dominant bit
`define BM_DOM_CYC 8'h08

`endif

// file: hw/boot_mode_pkg.sv
package boot_mode_pkg;

  // Captured boot select pins
  typedef struct packed {
    logic high;
    logic low;
  } boot_sel_t;

  // Contents of the two signature locations
  typedef struct packed {
    logic [15:0] word1;
    logic [15:0] word0;
  } user_sig_t;

  // Boot status seen by the rest of the chip
  typedef struct packed {
    logic [1:0] path;
    logic fetch_boot_flash;
    logic sw_reset;
    logic user_code;
    logic uart_boot;
    logic can_boot;
    logic endless_loop;
    logic reserved;
  } boot_status_t;

  // Sequencer states, one-hot
  typedef enum logic [10:0] {
    ST_WAIT = 11'h001,
    ST_DECODE = 11'h002,
    ST_SIG = 11'h004,
    ST_KEY = 11'h008,
    ST_SWRST = 11'h010,
    ST_USER = 11'h020,
    ST_SCAN = 11'h040,
    ST_UART = 11'h080,
    ST_CAN = 11'h100,
    ST_LOOP = 11'h200,
    ST_RSVD = 11'h400
  } boot_state_t;

endpackage : boot_mode_pkg

// file: tb/host_model.sv
`timescale 1ns/100ps
module host_model (
  // Clock
  input wire logic clk_in,
  // Lines toward the device, both idle high
  output logic uart_line_out,
  output logic can_line_out
);
  initial begin
    uart_line_out = 1'b1;
    can_line_out = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // UART start bit, low for four cycles, then back to idle
  task automatic send_start();
    @(posedge clk_in);
    #1 uart_line_out = 1'b0;
    repeat (4) @(posedge clk_in);
    #1 uart_line_out = 1'b1;
  endtask : send_start

  // CAN dominant bit, low long enough to count as valid
  task automatic send_dominant();
    @(posedge clk_in);
    #1 can_line_out = 1'b0;
    repeat (4) @(posedge clk_in);
    #1 can_line_out = 1'b1;
  endtask : send_dominant
endmodule : host_model

// file: tb/tb_top.sv
`timescale 1ns/100ps
`include "boot_mode_map.svh"
module tb_top;
  import boot_mode_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic pin = 1'b0;
  boot_sel_t sel = 2'h0;
  user_sig_t sig = 32'h0000_0000;
  logic [15:0] key = 16'h0000;
  logic uart_line;
  logic can_line;
  boot_status_t status_out;
  int fail_count = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h0001_57C5;
  logic [1:0] last_sel = 2'h0;
  boot_status_t exp_q[$];

  // Clock, 4 ns period
  always #2 clk_in = ~clk_in;

  boot_mode_selector #(.SWRST_CYC(8'h03), .DOM_CYC(8'h02)) dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .external_reset_input_in(pin),
    .boot_select_high_bit_in(sel.high), .boot_select_low_bit_in(sel.low),
    .user_sig_in(sig), .user_key_in(key), .uart_receive_line_in(uart_line),
    .first_can_receive_line_in(can_line), .status_out(status_out));

  host_model host (.clk_in(clk_in), .uart_line_out(uart_line), .can_line_out(can_line));

  ////////////////////////////////////////////////////////////////////////////
  // Random source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Expected status; ev 1 UART, 2 CAN, 3 CAN then UART
  function automatic boot_status_t expect_of(logic [1:0] s, bit ok, logic [15:0] k, int ev);
    boot_status_t e;
    bit alt_miss;
    bit en_u;
    bit en_c;
    e = '0;
    e.path = s;
    alt_miss = (s == `BM_SEL_ALT) && !ok;
    en_u = (s == `BM_SEL_STD) || (alt_miss && (k == `BM_KEY_STD || k == `BM_KEY_UART));
    en_c = (s == `BM_SEL_STD) || (alt_miss && (k == `BM_KEY_STD || k == `BM_KEY_CAN));
    if (s == `BM_SEL_RSVD) e.reserved = 1'b1;
    if (s == `BM_SEL_USER || (s == `BM_SEL_ALT && ok)) e.user_code = 1'b1;
    if (alt_miss && !en_u && !en_c) begin
      e.endless_loop = 1'b1;
      e.fetch_boot_flash = 1'b1;
    end
    if (en_u || en_c) e.fetch_boot_flash = 1'b1;
    if (ev == 1 && en_u) e.uart_boot = 1'b1;
    else if (ev >= 2 && en_c) e.can_boot = 1'b1;
    else if (ev == 3 && en_u) e.uart_boot = 1'b1;
    return e;
  endfunction : expect_of

  task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One boot: pin low, capture select, optional channel events
  task automatic run(input logic [1:0] s, input bit ok, input logic [15:0] k, input int ev);
    logic [15:0] w0;
    w0 = 16'(rnd());
    exp_q.push_back(expect_of(s, ok, k, 0));
    exp_q.push_back(expect_of(s, ok, k, ev));
    @(posedge clk_in);
    #1 pin = 1'b0;
    sel = s;
    key = k;
    sig.word0 = w0;
    sig.word1 = `BM_REF_SIG - w0 + (ok ? 16'h0000 : 16'h0001);
    repeat (2) @(posedge clk_in);
    #1 check(status_out, {last_sel, 7'h00}, "status while pin low");
    pin = 1'b1;
    last_sel = s;
    repeat (3) @(posedge clk_in);
    #1;
    if (s == 2'h1 && ok) check({8'h00, status_out.sw_reset}, 9'h001, "software reset");
    repeat (12) @(posedge clk_in);
    #1 check(status_out, exp_q.pop_front(), "status after capture");
    if (ev == 1) host.send_start();
    if (ev >= 2) host.send_dominant();
    if (ev == 3) host.send_start();
    repeat (6) @(posedge clk_in);
    #1 check(status_out, exp_q.pop_front(), "status after channel");
    $display("case sel=%0d ok=%0d key=%h ev=%0d done", s, ok, k, ev);
  endtask : run

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [15:0] k;
    repeat (6) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    run(2'h3, 1'b0, 16'h0000, 1);
    run(2'h0, 1'b0, 16'h0000, 2);
    for (int ev = 1; ev <= 3; ev++) run(2'h2, 1'b0, 16'h0000, ev);
    run(2'h1, 1'b1, 16'h0002, 1);
    for (int kk = 1; kk <= 3; kk++) begin
      for (int ev = 1; ev <= 3; ev++) run(2'h1, 1'b0, kk[15:0], ev);
    end
    k = 16'(rnd());
    if (k < 16'h0004) k = k | 16'h0100;
    run(2'h1, 1'b0, k, 1);
    final_report();
  end

  // Watchdog over the whole run
  initial begin
    #20000;
    fail_count++;
    final_report();
  end
endmodule : tb_top
